// [pkg/flash_guard_map.vh]
// constants for the flash write/erase guard and reset-source logic
// assumes a 10 MHz system clock; included by bare name
`ifndef FLASH_GUARD_MAP_VH
`define FLASH_GUARD_MAP_VH
// register offsets on the special-function register port
`define RST_SRC_OFS 8'hEF
`define PS_CTL_OFS 8'h8F
`define FL_KEY_OFS 8'hB7
`define PFCTL_OFS 8'hAF
// reset-source register bit positions
`define RS_PIN_BIT 0
`define RS_POR_BIT 1
`define RS_MCD_BIT 2
`define RS_WDT_BIT 3
`define RS_SOFT_BIT 4
`define RS_COMP_BIT 5
`define RS_FERR_BIT 6
`define RS_RTC_BIT 7
// program-store control and prefetch control bit positions
`define PS_WE_BIT 0
`define PS_EE_BIT 1
`define PF_BWE_BIT 0
// key codes
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
// flash geometry and contents
`define PAGE_MASK 16'hFE00
`define ERASED_BYTE 8'hFF
// reset values
`define PS_CTL_RST 2'h0
`define PFCTL_RST 1'h0
`define VDM_SRC_RST 1'h1
// timing
`define CLK_PERIOD_NS 100
`define PROG_TIME_NS 40000
`define PROG_CYC 18'h0_0190
`define ERASE_TIME_NS 20000000
`define ERASE_CYC 18'h3_0D40
`define RST_HOLD_CYC 3'h4
`endif

// [hw/flash_op_timer.v]
// self-timed duration counter for flash program and erase operations
// assumes start is a one-cycle pulse; count is sampled only in the cycle that start is high
`include "flash_guard_map.vh"
module flash_op_timer (
  input wire clock_i,
  input wire rst_n_i,
  input wire start_i,
  input wire abort_i,
  input wire [17:0] count_i,
  output wire busy_o,
  output reg done_o
);
  reg [17:0] left_ff; // cycles still to run
  reg run_ff; // operation in progress

  assign busy_o = run_ff;

  // count down; done pulses on the last cycle of the operation
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_ff <= 18'h0_0000;
      run_ff <= 1'b0;
      done_o <= 1'b0;
    end else if (abort_i) begin
      left_ff <= 18'h0_0000; // system reset kills any operation
      run_ff <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      left_ff <= count_i;
      run_ff <= 1'b1;
      done_o <= 1'b0;
    end else if (run_ff) begin
      left_ff <= left_ff - 18'h0_0001;
      done_o <= (left_ff == 18'h0_0002);
      if (left_ff == 18'h0_0001) begin
        run_ff <= 1'b0;
      end
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// [hw/flash_write_erase_guard.v]
// flash write/erase guard: key lock, write/erase enables, block writes,
// self-timed program/erase with core stall, flash-error detection and
// the reset-source register. assumes the core drives one-cycle strobes
// synchronous to clock_i and that rst_n_i is the power-on reset.
//
// Overview of operation
// [R1] enabled write above lock byte: error reset
// [R2] code read above lock byte: error reset
// [R3] branch above lock byte: error reset
// [R4] security-restricted access: error reset
// [R5] write/erase without supply monitor: error reset
// [R6] flash error flag bit 6, pin untouched
// [R7] bit 7 enables rtc reset, flags it
// [R8] bit 4 write-one forces soft reset
// [R9] two key codes, fixed order
// [R10] wrong or misordered code blocks until reset
// [R11] operation before key complete blocks until reset
// [R12] key re-arms after every operation
// [R13] write enable redirects moves; sticks until cleared
// [R14] program clears bits only; erase gives ones
// [R15] erase plus write enable erases page
// [R16] hardware timed, core stalls meanwhile
// [R17] single mode programs each byte
// [R18] block mode holds even, programs on odd
// [R19] block program same duration as single
// [R20] software pads unused byte, even first
// [R21] software page-erase sequence
// [R22] software single-byte sequence
// [R23] software block sequence, key per byte
// [R24] blocked write discarded, no stall
// [R25] power-on flag bit 1; selects monitor
// [R26] bit 2 enables clock detector, flags it
// [R27] bit 5 enables comparator reset, flags it
// [R28] bit 0 flags pin reset
`include "flash_guard_map.vh"
module flash_write_erase_guard #(
  parameter [17:0] ERASE_CYC = `ERASE_CYC // shorten in simulation
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  input wire xmove_wr_i,
  input wire [15:0] xmove_addr_i,
  input wire [7:0] xmove_data_i,
  input wire code_rd_i,
  input wire [15:0] code_addr_i,
  input wire branch_fetch_i,
  input wire [15:0] branch_addr_i,
  input wire [15:0] lock_byte_addr_i,
  input wire access_restricted_i,
  input wire [15:0] flash_rdata_i,
  input wire monitor_on_i,
  input wire supply_low_i,
  input wire pin_reset_i,
  input wire clock_loss_i,
  input wire comparator_low_i,
  input wire watchdog_i,
  input wire rtc_event_i,
  output wire cpu_stall_o,
  output reg flash_wr_o,
  output reg flash_erase_o,
  output reg [15:0] flash_addr_o,
  output reg [15:0] flash_wdata_o,
  output reg [1:0] flash_be_o,
  output reg sys_reset_o,
  output reg rst_pin_drive_o
);
  // key lock states
  localparam [3:0] KEY_IDLE = 4'b0001;
  localparam [3:0] KEY_HALF = 4'b0010;
  localparam [3:0] KEY_OPEN = 4'b0100;
  localparam [3:0] KEY_BLOCKED = 4'b1000;
  // operation sequencer states
  localparam [3:0] SEQ_IDLE = 4'b0001;
  localparam [3:0] SEQ_MERGE = 4'b0010;
  localparam [3:0] SEQ_PROG = 4'b0100;
  localparam [3:0] SEQ_ERASE = 4'b1000;
  localparam [17:0] PROG_CYC = `PROG_CYC;

  reg [3:0] key_ff; // key lock state
  reg [3:0] nxt_key;
  reg [3:0] seq_ff; // sequencer state
  reg [3:0] nxt_seq;
  reg flash_write_enable_ff; // program-store write enable
  reg flash_erase_enable_ff; // program-store erase enable
  reg block_write_select_ff; // two-byte block mode
  reg [7:0] even_hold_ff; // held even byte in block mode
  reg [15:0] new_data_ff; // bytes to merge with old contents
  reg [7:0] flags_ff; // reset cause flags as read back
  reg vdm_src_ff; // supply monitor selected as reset source
  reg mcd_en_ff; // missing-clock detector enable
  reg comp_en_ff; // comparator reset enable
  reg rtc_en_ff; // real-time-clock reset enable
  reg [2:0] hold_ff; // system reset cycles left
  reg [7:0] nxt_flags;
  reg nxt_pin;
  wire timer_busy;
  wire timer_done;
  wire timer_start;

  // register port decodes
  wire wr_rst = sfr_wr_i && (sfr_addr_i == `RST_SRC_OFS);
  wire wr_ps = sfr_wr_i && (sfr_addr_i == `PS_CTL_OFS);
  wire wr_key = sfr_wr_i && (sfr_addr_i == `FL_KEY_OFS);
  wire wr_pf = sfr_wr_i && (sfr_addr_i == `PFCTL_OFS);

  // flash move attempts and their legality
  wire mv_flash = xmove_wr_i && flash_write_enable_ff; // R13
  wire above_lock = xmove_addr_i > lock_byte_addr_i;
  wire no_monitor = !(monitor_on_i && vdm_src_ff);
  wire err_move = mv_flash && (above_lock || access_restricted_i || no_monitor); // R1 R4 R5
  wire err_code = code_rd_i && ((code_addr_i > lock_byte_addr_i) || access_restricted_i); // R2 R4
  wire err_branch = branch_fetch_i
    && ((branch_addr_i > lock_byte_addr_i) || access_restricted_i); // R3 R4
  wire flash_err = err_move || err_code || err_branch;
  wire in_reset = (hold_ff != 3'h0);
  // a legal, keyed move; the sequencer takes it only when idle
  wire mv_ok = mv_flash && !err_move && (key_ff == KEY_OPEN) && (seq_ff == SEQ_IDLE);
  wire is_odd = xmove_addr_i[0];
  wire hold_even = mv_ok && !flash_erase_enable_ff && block_write_select_ff && !is_odd;
  wire start_op = mv_ok && !hold_even;

  // reset causes; the soft reset is a write of one to bit 4
  wire soft_req = wr_rst && sfr_wdata_i[`RS_SOFT_BIT]; // R8
  wire vdm_req = supply_low_i && monitor_on_i && vdm_src_ff;
  wire mcd_req = clock_loss_i && mcd_en_ff; // R26
  wire comp_req = comparator_low_i && comp_en_ff; // R27
  wire rtc_req = rtc_event_i && rtc_en_ff; // R7
  wire any_req = vdm_req || pin_reset_i || mcd_req || comp_req || watchdog_i
    || rtc_req || soft_req || flash_err;

  // stall the core for the whole timed operation, not for held bytes
  assign cpu_stall_o = (seq_ff != SEQ_IDLE) || start_op; // R16 R24

  // cause capture: the supply monitor wins, then the pin, then the rest;
  // every other cause clears the power-on flag
  always @* begin
    nxt_flags = 8'h00;
    nxt_pin = 1'b0;
    if (vdm_req) begin
      nxt_flags[`RS_POR_BIT] = 1'b1; // R25
      nxt_pin = 1'b1;
    end else if (pin_reset_i) begin
      nxt_flags[`RS_PIN_BIT] = 1'b1; // R28
    end else if (flash_err) begin
      nxt_flags[`RS_FERR_BIT] = 1'b1; // R6
    end else if (mcd_req) begin
      nxt_flags[`RS_MCD_BIT] = 1'b1; // R26
    end else if (comp_req) begin
      nxt_flags[`RS_COMP_BIT] = 1'b1; // R27
    end else if (watchdog_i) begin
      nxt_flags[`RS_WDT_BIT] = 1'b1;
    end else if (rtc_req) begin
      nxt_flags[`RS_RTC_BIT] = 1'b1; // R7
    end else begin
      nxt_flags[`RS_SOFT_BIT] = 1'b1; // R8
    end
  end

  // reset generator and reset-source register
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff <= 3'h0;
      sys_reset_o <= 1'b0;
      rst_pin_drive_o <= 1'b0;
      flags_ff <= 8'h02; // power-on flag only
      vdm_src_ff <= `VDM_SRC_RST;
      mcd_en_ff <= 1'b0;
      comp_en_ff <= 1'b0;
      rtc_en_ff <= 1'b0;
    end else if (in_reset) begin
      // causes during the hold are ignored; enables except the monitor clear
      hold_ff <= hold_ff - 3'h1;
      sys_reset_o <= (hold_ff != 3'h1);
      rst_pin_drive_o <= rst_pin_drive_o && (hold_ff != 3'h1);
      mcd_en_ff <= 1'b0;
      comp_en_ff <= 1'b0;
      rtc_en_ff <= 1'b0;
    end else if (any_req) begin
      // only the supply monitor drives the pin; the others leave it alone
      hold_ff <= `RST_HOLD_CYC;
      sys_reset_o <= 1'b1;
      rst_pin_drive_o <= nxt_pin; // R6 R7 R8
      flags_ff <= nxt_flags;
    end else if (wr_rst) begin
      // writes load enables; flags are read-only images of the last cause
      vdm_src_ff <= sfr_wdata_i[`RS_POR_BIT]; // R25
      mcd_en_ff <= sfr_wdata_i[`RS_MCD_BIT]; // R26
      comp_en_ff <= sfr_wdata_i[`RS_COMP_BIT]; // R27
      rtc_en_ff <= sfr_wdata_i[`RS_RTC_BIT]; // R7
    end
  end

  // key lock: any surprise locks writes and erases out until reset
  always @* begin
    nxt_key = key_ff;
    case (key_ff)
      KEY_IDLE: begin
        if (wr_key) begin
          nxt_key = (sfr_wdata_i == `KEY_FIRST) ? KEY_HALF : KEY_BLOCKED; // R9 R10
        end else if (mv_flash && !err_move) begin
          nxt_key = KEY_BLOCKED; // R11
        end
      end
      KEY_HALF: begin
        if (wr_key) begin
          nxt_key = (sfr_wdata_i == `KEY_SECOND) ? KEY_OPEN : KEY_BLOCKED; // R9 R10
        end else if (mv_flash && !err_move) begin
          nxt_key = KEY_BLOCKED; // R11
        end
      end
      KEY_OPEN: begin
        if (wr_key) begin
          nxt_key = KEY_BLOCKED; // R10
        end else if (mv_ok) begin
          nxt_key = KEY_IDLE; // R12
        end
      end
      KEY_BLOCKED: begin
        nxt_key = KEY_BLOCKED; // R10 R24
      end
      default: begin
        nxt_key = KEY_BLOCKED;
      end
    endcase
  end

  // sequencer: merge old contents for a program, then run the timed operation
  always @* begin
    nxt_seq = seq_ff;
    case (seq_ff)
      SEQ_IDLE: begin
        if (start_op && flash_erase_enable_ff) begin
          nxt_seq = SEQ_ERASE; // R15
        end else if (start_op) begin
          nxt_seq = SEQ_MERGE; // R17 R18
        end
      end
      SEQ_MERGE: begin
        nxt_seq = SEQ_PROG;
      end
      SEQ_PROG: begin
        if (timer_done) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      SEQ_ERASE: begin
        if (timer_done) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      default: begin
        nxt_seq = SEQ_IDLE;
      end
    endcase
  end

  // timer starts when the merged data is ready or an erase begins
  assign timer_start = (seq_ff == SEQ_MERGE) || (seq_ff == SEQ_IDLE && nxt_seq == SEQ_ERASE);

  // control state, cleared by any system reset as well as power-on
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_ff <= KEY_IDLE;
      seq_ff <= SEQ_IDLE;
      flash_write_enable_ff <= 1'b0;
      flash_erase_enable_ff <= 1'b0;
      block_write_select_ff <= `PFCTL_RST;
    end else if (in_reset || any_req) begin
      key_ff <= KEY_IDLE;
      seq_ff <= SEQ_IDLE;
      flash_write_enable_ff <= 1'b0;
      flash_erase_enable_ff <= 1'b0;
      block_write_select_ff <= `PFCTL_RST;
    end else begin
      key_ff <= nxt_key;
      seq_ff <= nxt_seq;
      if (wr_ps) begin
        // enables stay as written until software or a system reset changes them
        flash_write_enable_ff <= sfr_wdata_i[`PS_WE_BIT]; // R13
        flash_erase_enable_ff <= sfr_wdata_i[`PS_EE_BIT];
      end
      if (wr_pf) begin
        block_write_select_ff <= sfr_wdata_i[`PF_BWE_BIT];
      end
    end
  end

  // flash datapath: address, byte lanes, merged write data
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      even_hold_ff <= `ERASED_BYTE;
      new_data_ff <= 16'hFFFF;
      flash_addr_o <= 16'h0000;
      flash_wdata_o <= 16'hFFFF;
      flash_be_o <= 2'b00;
      flash_wr_o <= 1'b0;
      flash_erase_o <= 1'b0;
    end else if (in_reset || any_req) begin
      // an operation cut short by reset leaves flash as it stood
      even_hold_ff <= `ERASED_BYTE;
      flash_wr_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_be_o <= 2'b00;
    end else begin
      if (hold_even) begin
        even_hold_ff <= xmove_data_i; // R18
      end
      if (start_op && flash_erase_enable_ff) begin
        flash_addr_o <= xmove_addr_i & `PAGE_MASK; // R15
        flash_wdata_o <= 16'hFFFF; // R14
        flash_erase_o <= 1'b1;
        flash_be_o <= 2'b11;
      end else if (start_op && block_write_select_ff) begin
        // pair program; an unwritten even byte stays at ones
        flash_addr_o <= {xmove_addr_i[15:1], 1'b0};
        new_data_ff <= {xmove_data_i, even_hold_ff}; // R18 R20
        flash_be_o <= 2'b11;
        even_hold_ff <= `ERASED_BYTE;
      end else if (start_op) begin
        flash_addr_o <= {xmove_addr_i[15:1], 1'b0};
        new_data_ff <= is_odd ? {xmove_data_i, `ERASED_BYTE}
          : {`ERASED_BYTE, xmove_data_i}; // R17
        flash_be_o <= is_odd ? 2'b10 : 2'b01;
      end
      if (seq_ff == SEQ_MERGE) begin
        // and with old contents so programming only clears bits
        flash_wdata_o <= new_data_ff & flash_rdata_i; // R14
        flash_wr_o <= 1'b1;
      end
      if (timer_done) begin
        flash_wr_o <= 1'b0;
        flash_erase_o <= 1'b0;
        flash_be_o <= 2'b00;
      end
    end
  end

  // one duration for single and pair programs; erase has its own
  flash_op_timer u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(timer_start),
    .abort_i(in_reset || any_req),
    .count_i((seq_ff == SEQ_MERGE) ? PROG_CYC : ERASE_CYC), // R16 R19
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // register read port; one cycle latency, unmapped reads give zero
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `RST_SRC_OFS: sfr_rdata_o <= flags_ff; // R6 R7 R8 R25 R26 R27 R28
        `PS_CTL_OFS: sfr_rdata_o <= {6'h00, flash_erase_enable_ff, flash_write_enable_ff};
        `FL_KEY_OFS: sfr_rdata_o <= {5'h00, timer_busy, key_ff == KEY_BLOCKED,
          key_ff == KEY_OPEN};
        `PFCTL_OFS: sfr_rdata_o <= {7'h00, block_write_select_ff};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// [bench/flash_array_model.sv]
// behavioural flash array standing behind the guard's flash port
// assumes pair addresses with bit 0 low and two 512-byte pages
module flash_array_model (
  input wire logic clock_i,
  input wire logic flash_wr_i,
  input wire logic flash_erase_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic [15:0] flash_wdata_i,
  input wire logic [1:0] flash_be_i,
  output logic [15:0] flash_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:1023]; // blank part starts erased
  logic [9:0] pair; // even byte of the addressed pair
  assign pair = {flash_addr_i[9:1], 1'b0};
  assign flash_rdata_o = {mem[pair | 10'h001], mem[pair]};
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
  end
  // cells only lose ones when written, like the real array
  always @(posedge clock_i) begin
    if (flash_erase_i) begin
      for (int i = 0; i < 512; i++) mem[{flash_addr_i[9], i[8:0]}] <= 8'hFF;
    end
    if (flash_wr_i && flash_be_i[0]) mem[pair] <= mem[pair] & flash_wdata_i[7:0];
    if (flash_wr_i && flash_be_i[1]) begin
      mem[pair | 10'h001] <= mem[pair | 10'h001] & flash_wdata_i[15:8];
    end
  end
endmodule

// [bench/flash_guard_asserts.sv]
// port-level checker for the flash write/erase guard
// assumes one clock domain and the guard's asynchronous active-low reset
module guard_asserts #(
  parameter [17:0] ERASE_CYC = 18'h0_0014
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic xmove_wr_i,
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  input wire logic branch_fetch_i,
  input wire logic [15:0] branch_addr_i,
  input wire logic [15:0] lock_byte_addr_i,
  input wire logic access_restricted_i,
  input wire logic supply_low_i,
  input wire logic [15:0] flash_rdata_i,
  input wire logic cpu_stall_o,
  input wire logic flash_wr_o,
  input wire logic flash_erase_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic [15:0] flash_wdata_o,
  input wire logic [1:0] flash_be_o,
  input wire logic sys_reset_o,
  input wire logic rst_pin_drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [9:0] span_ff; // cycles the current program has lasted
  logic [15:0] lane_m; // byte lanes being programmed
  assign lane_m = {{8{flash_be_o[1]}}, {8{flash_be_o[0]}}};
  // span counter, cleared whenever no program runs
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) span_ff <= 10'h000;
    else span_ff <= flash_wr_o ? span_ff + 10'h001 : 10'h000;
  end
  AST_CODE_HIGH: assert property (
    code_rd_i && code_addr_i > lock_byte_addr_i && !sys_reset_o |=> sys_reset_o)
    else $error("code read above lock byte gave no reset");
  AST_BRANCH_HIGH: assert property (
    branch_fetch_i && branch_addr_i > lock_byte_addr_i && !sys_reset_o |=> sys_reset_o)
    else $error("branch above lock byte gave no reset");
  AST_RESTRICTED: assert property (
    (code_rd_i || branch_fetch_i) && access_restricted_i && !sys_reset_o |=> sys_reset_o)
    else $error("restricted read gave no reset");
  AST_PIN_QUIET: assert property (
    $rose(sys_reset_o) && !$past(supply_low_i) |-> !rst_pin_drive_o [*4])
    else $error("reset pin driven by internal reset");
  AST_HOLD_FOUR: assert property ($rose(sys_reset_o) |-> sys_reset_o [*4] ##1 !sys_reset_o)
    else $error("system reset length wrong");
  AST_STALL: assert property (flash_wr_o || flash_erase_o |-> cpu_stall_o)
    else $error("core not stalled during flash operation");
  AST_PROG_SPAN: assert property (
    $fell(flash_wr_o) |-> span_ff >= 10'h186 && span_ff <= 10'h19A)
    else $error("program duration out of range");
  AST_PROG_CAUSE: assert property (
    $rose(flash_wr_o) |-> $past(xmove_wr_i, 2) && !flash_addr_o[0])
    else $error("program without a move two cycles before");
  AST_ERASE_PAGE: assert property (
    $rose(flash_erase_o) |-> $past(xmove_wr_i) && flash_addr_o[8:0] == 9'h000)
    else $error("erase not at page base or without move");
  AST_CLEAR_ONLY: assert property (
    flash_wr_o |-> (flash_wdata_o & lane_m & ~flash_rdata_i) == 16'h0000)
    else $error("program would set a cleared bit");
  cover property ($rose(flash_wr_o));
  cover property ($rose(flash_erase_o));
  cover property ($rose(sys_reset_o));
endmodule
bind flash_write_erase_guard guard_asserts #(.ERASE_CYC(ERASE_CYC)) i_chk (.clock_i, .rst_n_i,
  .xmove_wr_i, .code_rd_i, .code_addr_i, .branch_fetch_i, .branch_addr_i, .lock_byte_addr_i,
  .access_restricted_i, .supply_low_i, .flash_rdata_i, .cpu_stall_o, .flash_wr_o,
  .flash_erase_o, .flash_addr_o, .flash_wdata_o, .flash_be_o, .sys_reset_o, .rst_pin_drive_o);

// [bench/flash_write_erase_guard_tb.sv]
// self-checking bench for the flash write/erase guard
// assumes the flash array model and the bound port checker
`include "flash_guard_map.vh"
module flash_write_erase_guard_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_n_i, sfr_wr_i, sfr_rd_i, xmove_wr_i, code_rd_i, branch_fetch_i;
  logic access_restricted_i, monitor_on_i, supply_low_i, pin_reset_i, clock_loss_i;
  logic comparator_low_i, watchdog_i, rtc_event_i, cpu_stall_o, flash_wr_o;
  logic flash_erase_o, sys_reset_o, rst_pin_drive_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xmove_data_i, v;
  logic [15:0] xmove_addr_i, code_addr_i, branch_addr_i, lock_byte_addr_i, flash_rdata_i;
  logic [15:0] flash_addr_o, flash_wdata_o;
  logic [1:0] flash_be_o;
  int err_count, total_checks, n1;
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  flash_write_erase_guard #(.ERASE_CYC(18'h0_0014)) i_dut (.clock_i, .rst_n_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .xmove_wr_i, .xmove_addr_i,
    .xmove_data_i, .code_rd_i, .code_addr_i, .branch_fetch_i, .branch_addr_i,
    .lock_byte_addr_i, .access_restricted_i, .flash_rdata_i, .monitor_on_i, .supply_low_i,
    .pin_reset_i, .clock_loss_i, .comparator_low_i, .watchdog_i, .rtc_event_i, .cpu_stall_o,
    .flash_wr_o, .flash_erase_o, .flash_addr_o, .flash_wdata_o, .flash_be_o, .sys_reset_o,
    .rst_pin_drive_o);
  flash_array_model i_flash (.clock_i, .flash_wr_i(flash_wr_o), .flash_erase_i(flash_erase_o),
    .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o), .flash_be_i(flash_be_o),
    .flash_rdata_o(flash_rdata_i));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, a, d};
    @(negedge clock_i);
    sfr_wr_i = 1'b0;
  endtask
  task sfr_rd(input logic [7:0] a);
    @(negedge clock_i);
    {sfr_rd_i, sfr_addr_i} = {1'b1, a};
    @(negedge clock_i);
    sfr_rd_i = 1'b0;
    v = sfr_rdata_o;
  endtask
  // one core strobe: 0 code read, 1 branch, 2 restricted read, 3/4 move
  task strobe(input int k, input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    code_rd_i = (k == 0 || k == 2);
    branch_fetch_i = (k == 1);
    access_restricted_i = (k == 2);
    xmove_wr_i = (k >= 3);
    {code_addr_i, branch_addr_i, xmove_addr_i, xmove_data_i} = {a, a, a, d};
    @(negedge clock_i);
    {code_rd_i, branch_fetch_i, access_restricted_i, xmove_wr_i} = 4'h0;
  endtask
  task arm(input logic [7:0] ps);
    sfr_wr(`FL_KEY_OFS, `KEY_FIRST);
    sfr_wr(`FL_KEY_OFS, `KEY_SECOND);
    sfr_wr(`PS_CTL_OFS, ps);
  endtask
  // count stalled cycles under a bound, then drop the enables
  task run(output int n);
    n = 0;
    while (cpu_stall_o === 1'b1 && n < 1000) begin
      @(negedge clock_i);
      n++;
    end
    sfr_wr(`PS_CTL_OFS, 8'h00);
  endtask
  task settle(input logic [7:0] flag);
    @(negedge clock_i);
    chk(sys_reset_o, 16'h0001);
    chk(rst_pin_drive_o, 16'h0000);
    repeat (6) @(negedge clock_i);
    sfr_rd(`RST_SRC_OFS);
    chk(v & 8'hFD, flag);
  endtask
  task pulse(input int k);
    @(negedge clock_i);
    {rtc_event_i, comparator_low_i, clock_loss_i, pin_reset_i, watchdog_i} = 5'h10 >> k;
    @(negedge clock_i);
    {rtc_event_i, comparator_low_i, clock_loss_i, pin_reset_i, watchdog_i} = 5'h00;
  endtask
  // supply monitor reset: the only cause allowed to drive the pin
  task t_vdm;
    @(negedge clock_i);
    supply_low_i = 1'b1;
    @(negedge clock_i);
    supply_low_i = 1'b0;
    @(negedge clock_i);
    chk(sys_reset_o, 16'h0001);
    chk(rst_pin_drive_o, 16'h0001);
    repeat (6) @(negedge clock_i);
    sfr_rd(`RST_SRC_OFS);
    chk(v, 16'h0002);
  endtask
  task t_single;
    int n;
    arm(8'h01);
    strobe(3, 16'h0010, 8'h5A);
    chk(cpu_stall_o, 16'h0001);
    run(n1);
    chk(n1 >= 390 && n1 <= 410, 16'h0001);
    chk(i_flash.mem[16], 16'h005A);
    arm(8'h01);
    strobe(3, 16'h0010, 8'hF0);
    run(n);
    chk(i_flash.mem[16], 16'h0050);
  endtask
  task t_block;
    int n;
    sfr_wr(`PFCTL_OFS, 8'h01);
    arm(8'h01);
    strobe(3, 16'h0020, 8'h12);
    chk(cpu_stall_o, 16'h0000);
    chk(i_flash.mem[32], 16'h00FF);
    sfr_wr(`PS_CTL_OFS, 8'h00);
    arm(8'h01);
    strobe(3, 16'h0021, 8'h34);
    run(n);
    chk(n, n1);
    chk({i_flash.mem[33], i_flash.mem[32]}, 16'h3412);
    sfr_wr(`PFCTL_OFS, 8'h00);
  endtask
  task t_erase;
    int n;
    arm(8'h03);
    strobe(3, 16'h0015, 8'h00);
    chk(flash_erase_o, 16'h0001);
    run(n);
    chk({i_flash.mem[16], i_flash.mem[33]}, 16'hFFFF);
  endtask
  task t_soft;
    sfr_wr(`RST_SRC_OFS, 8'h02);
    @(negedge clock_i);
    chk(sys_reset_o, 16'h0000);
    sfr_wr(`RST_SRC_OFS, 8'h12);
    settle(8'h10);
  endtask
  // 0 move before keys, 1 codes out of order, 2 wrong second code
  task t_badkey(input int k);
    if (k == 0) sfr_wr(`PS_CTL_OFS, 8'h01);
    if (k == 0) strobe(3, 16'h0040, 8'h00);
    if (k == 1) sfr_wr(`FL_KEY_OFS, `KEY_SECOND);
    if (k == 2) sfr_wr(`FL_KEY_OFS, `KEY_FIRST);
    if (k == 2) sfr_wr(`FL_KEY_OFS, 8'h00);
    arm(8'h01);
    strobe(3, 16'h0040, 8'h00);
    chk(cpu_stall_o, 16'h0000);
    chk(i_flash.mem[64], 16'h00FF);
    sfr_rd(`FL_KEY_OFS);
    chk(v & 8'h02, 16'h0002);
    sfr_wr(`PS_CTL_OFS, 8'h00);
    t_soft;
  endtask
  task t_err(input int k);
    if (k >= 3) arm(8'h01);
    monitor_on_i = (k != 4);
    strobe(k, (k == 2 || k == 4) ? 16'h0030 : 16'h0400, 8'h00);
    monitor_on_i = 1'b1;
    settle(8'h40);
    chk(i_flash.mem[48], 16'h00FF);
  endtask
  // 0 clock alarm, 1 comparator, 2 clock loss, 3 reset pin, 4 watchdog
  task t_src(input int k);
    logic [7:0] m;
    m = 8'h01 << (k == 0 ? 7 : k == 1 ? 5 : k == 2 ? 2 : k == 3 ? 0 : 3);
    if (k < 3) begin
      pulse(k);
      @(negedge clock_i);
      chk(sys_reset_o, 16'h0000);
      sfr_wr(`RST_SRC_OFS, m | 8'h02);
    end
    pulse(k);
    settle(m);
  endtask
  task final_report;
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {sfr_wr_i, sfr_rd_i, xmove_wr_i, code_rd_i, branch_fetch_i, access_restricted_i} = 6'h00;
    {supply_low_i, pin_reset_i, clock_loss_i, comparator_low_i, watchdog_i} = 5'h00;
    {rtc_event_i, monitor_on_i, rst_n_i} = 3'h2;
    {sfr_addr_i, sfr_wdata_i, xmove_data_i} = 24'h00_0000;
    {xmove_addr_i, code_addr_i, branch_addr_i} = 48'h0000_0000_0000;
    lock_byte_addr_i = 16'h03FF;
    repeat (4) @(negedge clock_i);
    rst_n_i = 1'b1;
    sfr_rd(`RST_SRC_OFS);
    chk(v, 16'h0002);
    sfr_rd(8'h10);
    chk(v, 16'h0000);
    t_single;
    t_block;
    t_erase;
    for (int k = 0; k < 3; k++) t_badkey(k);
    for (int k = 0; k < 5; k++) t_err(k);
    for (int k = 0; k < 5; k++) t_src(k);
    t_vdm;
    final_report;
  end
  initial begin
    #2_000_000;
    err_count++;
    final_report;
  end
endmodule
